// ### rtl/sps_pkg.sv
package sps_pkg;

  // Register byte offsets
  localparam logic [4:0] ADDR_CONFIG    = 5'h00;
  localparam logic [4:0] ADDR_COMMAND   = 5'h04;
  localparam logic [4:0] ADDR_CLOSE_TRV = 5'h08;
  localparam logic [4:0] ADDR_OPEN_TRV  = 5'h0c;
  localparam logic [4:0] ADDR_SETTLE    = 5'h10;
  localparam logic [4:0] ADDR_STATUS    = 5'h14;
  localparam logic [4:0] ADDR_IRQ_STAT  = 5'h18;
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h1c;

  // Config fields
  localparam int CFG_USE_CLOSED = 0;
  localparam int CFG_USE_OPEN   = 1;
  localparam logic [1:0] CFG_RESET = 2'h3;

  // Command fields
  localparam int CMD_CLOSE = 0;
  localparam int CMD_OPEN  = 1;

  // Status fields
  localparam int ST_CODE_LO   = 0;
  localparam int ST_CLOSED    = 2;
  localparam int ST_OPEN      = 3;
  localparam int ST_TRANSIT   = 4;
  localparam int ST_FAULT     = 5;
  localparam int ST_SINGLE    = 6;
  localparam int ST_SUCCEEDED = 7;
  localparam int ST_CLOSE_DRV = 8;
  localparam int ST_OPEN_DRV  = 9;

  // Interrupt fields
  localparam int IRQ_SUCCESS = 0;
  localparam int IRQ_FAULT   = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Position codes
  localparam logic [1:0] CODE_TRANSIT = 2'h0;
  localparam logic [1:0] CODE_OPEN    = 2'h1;
  localparam logic [1:0] CODE_CLOSED  = 2'h2;
  localparam logic [1:0] CODE_FAULT   = 2'h3;

  // Default timer counts in clock cycles
  localparam int CLOSE_TRV_RESET = 1000;
  localparam int OPEN_TRV_RESET  = 1000;
  localparam int SETTLE_RESET    = 0;

  typedef struct packed {
    logic atClosed;
    logic atOpen;
    logic inTransit;
    logic posFault;
  } sps_pos_s;

  typedef struct packed {
    logic useOpen;
    logic useClosed;
  } sps_cfg_s;

  typedef enum logic [2:0] {
    S_IDLE,
    S_MOVE_CLOSE,
    S_MOVE_OPEN,
    S_FAIL,
    S_SETTLE
  } sps_state_e;

endpackage

// ### rtl/sps_supervisor.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module sps_supervisor #(
  parameter int TW = 16
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [4:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Auxiliary contacts
  input  wire logic        closedAux,
  input  wire logic        openAux,
  // Command relays
  output logic             closeDrive,
  output logic             openDrive,
  // Position
  output logic             atClosed,
  output logic             atOpen,
  output logic             inTransit,
  output logic             posFault,
  output logic      [1:0]  posCode,
  output logic             singleContactFlag,
  output logic             commandSucceeded,
  // Interrupt
  output logic             irq
);

  if (TW < 2 || TW > 32) begin : gBadWidth
    $error("TW must be 2..32");
  end

  // Reset release
  logic [1:0] rstSync_ff;
  logic       rstN;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstN = rstSync_ff[1];

  // Contact synchronisers
  logic [2:0] syncC_ff, syncO_ff;
  logic       cStable_ff, oStable_ff, cPrev_ff, oPrev_ff;
  logic       nxt_cStable, nxt_oStable;

  always_comb begin
    nxt_cStable = cStable_ff;
    nxt_oStable = oStable_ff;
    if (syncC_ff[1] == syncC_ff[2]) begin
      nxt_cStable = syncC_ff[2];
    end
    if (syncO_ff[1] == syncO_ff[2]) begin
      nxt_oStable = syncO_ff[2];
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      syncC_ff   <= 3'h0;
      syncO_ff   <= 3'h0;
      cStable_ff <= 1'b0;
      oStable_ff <= 1'b0;
      cPrev_ff   <= 1'b0;
      oPrev_ff   <= 1'b0;
    end else begin
      syncC_ff   <= {syncC_ff[1:0], closedAux};
      syncO_ff   <= {syncO_ff[1:0], openAux};
      cStable_ff <= nxt_cStable;
      oStable_ff <= nxt_oStable;
      cPrev_ff   <= cStable_ff;
      oPrev_ff   <= oStable_ff;
    end
  end

  // Register file
  sps_pkg::sps_cfg_s cfg_ff, nxt_cfg;
  logic [TW-1:0]     closeTrv_ff, openTrv_ff, settle_ff;
  logic [TW-1:0]     nxt_closeTrv, nxt_openTrv, nxt_settle;
  logic [1:0]        irqStat_ff, irqMask_ff, nxt_irqStat, nxt_irqMask;
  logic [31:0]       nxt_rdata, statusWord;
  logic              nxt_irq, cmdClose, cmdOpen, evSuccess, evFault;

  assign cmdOpen  = regWr && regAddr == sps_pkg::ADDR_COMMAND && regWdata[sps_pkg::CMD_OPEN];
  assign cmdClose = regWr && regAddr == sps_pkg::ADDR_COMMAND && regWdata[sps_pkg::CMD_CLOSE]
                    && !regWdata[sps_pkg::CMD_OPEN];

  always_comb begin
    nxt_cfg      = cfg_ff;
    nxt_closeTrv = closeTrv_ff;
    nxt_openTrv  = openTrv_ff;
    nxt_settle   = settle_ff;
    nxt_irqMask  = irqMask_ff;
    nxt_irqStat  = irqStat_ff;
    if (regWr) begin
      unique case (regAddr)
        sps_pkg::ADDR_CONFIG:    nxt_cfg = regWdata[1:0];
        sps_pkg::ADDR_CLOSE_TRV: nxt_closeTrv = regWdata[TW-1:0];
        sps_pkg::ADDR_OPEN_TRV:  nxt_openTrv = regWdata[TW-1:0];
        sps_pkg::ADDR_SETTLE:    nxt_settle = regWdata[TW-1:0];
        sps_pkg::ADDR_IRQ_STAT:  nxt_irqStat = irqStat_ff & ~regWdata[1:0];
        sps_pkg::ADDR_IRQ_MASK:  nxt_irqMask = regWdata[1:0];
        default:                 ;
      endcase
    end
    // Set wins over clear
    nxt_irqStat[sps_pkg::IRQ_SUCCESS] = nxt_irqStat[sps_pkg::IRQ_SUCCESS] | evSuccess;
    nxt_irqStat[sps_pkg::IRQ_FAULT]   = nxt_irqStat[sps_pkg::IRQ_FAULT] | evFault;
    nxt_irq = |(nxt_irqStat & nxt_irqMask);
    nxt_rdata = 32'h0;
    if (regRd) begin
      unique case (regAddr)
        sps_pkg::ADDR_CONFIG:    nxt_rdata = {30'h0, cfg_ff};
        sps_pkg::ADDR_CLOSE_TRV: nxt_rdata = 32'(closeTrv_ff);
        sps_pkg::ADDR_OPEN_TRV:  nxt_rdata = 32'(openTrv_ff);
        sps_pkg::ADDR_SETTLE:    nxt_rdata = 32'(settle_ff);
        sps_pkg::ADDR_STATUS:    nxt_rdata = statusWord;
        sps_pkg::ADDR_IRQ_STAT:  nxt_rdata = {30'h0, irqStat_ff};
        sps_pkg::ADDR_IRQ_MASK:  nxt_rdata = {30'h0, irqMask_ff};
        default:                 nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cfg_ff      <= sps_pkg::CFG_RESET;
      closeTrv_ff <= TW'(sps_pkg::CLOSE_TRV_RESET);
      openTrv_ff  <= TW'(sps_pkg::OPEN_TRV_RESET);
      settle_ff   <= TW'(sps_pkg::SETTLE_RESET);
      irqStat_ff  <= 2'h0;
      irqMask_ff  <= sps_pkg::IRQ_MASK_RESET;
      regRdata    <= 32'h0;
      irq         <= 1'b0;
    end else begin
      cfg_ff      <= nxt_cfg;
      closeTrv_ff <= nxt_closeTrv;
      openTrv_ff  <= nxt_openTrv;
      settle_ff   <= nxt_settle;
      irqStat_ff  <= nxt_irqStat;
      irqMask_ff  <= nxt_irqMask;
      regRdata    <= nxt_rdata;
      irq         <= nxt_irq;
    end
  end

  // Configuration decode
  logic bothCfg, closedOnly, openOnly, singleCfg;

  assign bothCfg    = cfg_ff.useClosed && cfg_ff.useOpen;
  assign closedOnly = cfg_ff.useClosed && !cfg_ff.useOpen;
  assign openOnly   = !cfg_ff.useClosed && cfg_ff.useOpen;
  assign singleCfg  = closedOnly || openOnly;

  function automatic logic [TW-1:0] atLeastOne(input logic [TW-1:0] v);
    atLeastOne = (v == '0) ? TW'(1) : v;
  endfunction

  // Travel sequencer
  sps_pkg::sps_state_e state_ff, nxt_state;
  logic [TW-1:0]       cnt_ff, nxt_cnt;
  logic                toClosed_ff, nxt_toClosed, supervised_ff, nxt_supervised;
  logic                travelFail_ff, nxt_travelFail, assumeEnd_ff, nxt_assumeEnd;
  logic                succeeded_ff, nxt_succeeded;
  logic                reachedClosed, reachedOpen, contactChange;

  assign contactChange = (cStable_ff != cPrev_ff) || (oStable_ff != oPrev_ff);

  always_comb begin
    reachedClosed = 1'b0;
    reachedOpen   = 1'b0;
    if (bothCfg) begin
      reachedClosed = cStable_ff && !oStable_ff;
      reachedOpen   = !cStable_ff && oStable_ff;
    end else if (closedOnly) begin
      reachedClosed = cStable_ff;
      reachedOpen   = !cStable_ff;
    end else if (openOnly) begin
      reachedClosed = !oStable_ff;
      reachedOpen   = oStable_ff;
    end
  end

  always_comb begin
    nxt_state      = state_ff;
    nxt_cnt        = cnt_ff;
    nxt_toClosed   = toClosed_ff;
    nxt_supervised = supervised_ff;
    nxt_travelFail = travelFail_ff;
    nxt_assumeEnd  = assumeEnd_ff && !contactChange;
    nxt_succeeded  = succeeded_ff;
    evSuccess      = 1'b0;
    evFault        = 1'b0;
    if (cmdOpen || cmdClose) begin
      nxt_state      = cmdOpen ? sps_pkg::S_MOVE_OPEN : sps_pkg::S_MOVE_CLOSE;
      nxt_cnt        = atLeastOne(cmdOpen ? openTrv_ff : closeTrv_ff);
      nxt_toClosed   = cmdClose;
      nxt_supervised = bothCfg || (cmdClose && closedOnly) || (cmdOpen && openOnly);
      nxt_travelFail = 1'b0;
      nxt_assumeEnd  = 1'b0;
      nxt_succeeded  = 1'b0;
    end else begin
      unique case (state_ff)
        sps_pkg::S_IDLE: begin
        end
        sps_pkg::S_MOVE_CLOSE, sps_pkg::S_MOVE_OPEN: begin
          if (toClosed_ff ? reachedClosed : reachedOpen) begin
            nxt_state = sps_pkg::S_IDLE;
            if (supervised_ff) begin
              nxt_succeeded = 1'b1;
              evSuccess     = 1'b1;
            end
          end else if (cnt_ff <= TW'(1)) begin
            nxt_state = sps_pkg::S_IDLE;
            if (supervised_ff) begin
              nxt_travelFail = 1'b1;
              evFault        = 1'b1;
              if (singleCfg && settle_ff != '0) begin
                nxt_state = sps_pkg::S_FAIL;
              end
            end
          end else begin
            nxt_cnt = cnt_ff - TW'(1);
          end
        end
        sps_pkg::S_FAIL: begin
          nxt_state = sps_pkg::S_SETTLE;
          nxt_cnt   = settle_ff;
        end
        sps_pkg::S_SETTLE: begin
          if (cnt_ff <= TW'(1)) begin
            nxt_state      = sps_pkg::S_IDLE;
            nxt_travelFail = 1'b0;
            nxt_assumeEnd  = 1'b1;
          end else begin
            nxt_cnt = cnt_ff - TW'(1);
          end
        end
        default: begin
          nxt_state = sps_pkg::S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      state_ff      <= sps_pkg::S_IDLE;
      cnt_ff        <= '0;
      toClosed_ff   <= 1'b0;
      supervised_ff <= 1'b0;
      travelFail_ff <= 1'b0;
      assumeEnd_ff  <= 1'b0;
      succeeded_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      cnt_ff        <= nxt_cnt;
      toClosed_ff   <= nxt_toClosed;
      supervised_ff <= nxt_supervised;
      travelFail_ff <= nxt_travelFail;
      assumeEnd_ff  <= nxt_assumeEnd;
      succeeded_ff  <= nxt_succeeded;
    end
  end

  // Position evaluation
  sps_pkg::sps_pos_s pos;
  sps_pkg::sps_pos_s nxt_pos;
  logic [1:0]        nxt_code;
  logic              moving;

  assign moving = state_ff == sps_pkg::S_MOVE_CLOSE || state_ff == sps_pkg::S_MOVE_OPEN;

  function automatic logic [1:0] codeOf(input sps_pkg::sps_pos_s p);
    if (p.atClosed) codeOf = sps_pkg::CODE_CLOSED;
    else if (p.atOpen) codeOf = sps_pkg::CODE_OPEN;
    else if (p.posFault) codeOf = sps_pkg::CODE_FAULT;
    else codeOf = sps_pkg::CODE_TRANSIT;
  endfunction

  always_comb begin
    nxt_pos = '0;
    if (!cfg_ff.useClosed && !cfg_ff.useOpen) begin
      nxt_pos.posFault = 1'b1;
    end else if ((moving && supervised_ff) || state_ff == sps_pkg::S_SETTLE) begin
      nxt_pos.inTransit = 1'b1;
    end else if (state_ff == sps_pkg::S_FAIL || travelFail_ff) begin
      nxt_pos.posFault = 1'b1;
    end else if (assumeEnd_ff) begin
      nxt_pos.atClosed = toClosed_ff;
      nxt_pos.atOpen   = !toClosed_ff;
    end else if (bothCfg) begin
      nxt_pos.atClosed = cStable_ff && !oStable_ff;
      nxt_pos.atOpen   = !cStable_ff && oStable_ff;
      nxt_pos.posFault = cStable_ff == oStable_ff;
    end else if (closedOnly) begin
      nxt_pos.atClosed = cStable_ff;
      nxt_pos.atOpen   = !cStable_ff;
    end else begin
      nxt_pos.atOpen   = oStable_ff;
      nxt_pos.atClosed = !oStable_ff;
    end
    nxt_code = codeOf(nxt_pos);
  end

  assign pos = '{atClosed, atOpen, inTransit, posFault};

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      atClosed          <= 1'b0;
      atOpen            <= 1'b0;
      inTransit         <= 1'b1;
      posFault          <= 1'b0;
      posCode           <= sps_pkg::CODE_TRANSIT;
      singleContactFlag <= 1'b0;
      commandSucceeded  <= 1'b0;
      closeDrive        <= 1'b0;
      openDrive         <= 1'b0;
    end else begin
      atClosed          <= nxt_pos.atClosed;
      atOpen            <= nxt_pos.atOpen;
      inTransit         <= nxt_pos.inTransit;
      posFault          <= nxt_pos.posFault;
      posCode           <= nxt_code;
      singleContactFlag <= singleCfg;
      commandSucceeded  <= succeeded_ff;
      closeDrive        <= nxt_state == sps_pkg::S_MOVE_CLOSE;
      openDrive         <= nxt_state == sps_pkg::S_MOVE_OPEN;
    end
  end

  assign statusWord = {22'h0, openDrive, closeDrive, commandSucceeded, singleContactFlag,
                       pos.posFault, pos.inTransit, pos.atOpen, pos.atClosed, posCode};

endmodule

// ### verif/sps_contacts_model.sv
`timescale 1ns/1ps
module sps_contacts_model (
  // Clock
  input  wire logic       mclk,
  // Relay coils
  input  wire logic       closeDrive,
  input  wire logic       openDrive,
  // Behaviour: travel cycles (0 = stuck), forced levels
  input  wire logic [3:0] moveDelay,
  input  wire logic [1:0] forceLvl,
  // Auxiliary contacts
  output logic            closedAux,
  output logic            openAux
);
  logic [7:0] runCnt;
  logic       posClosed;
  initial begin
    runCnt = 8'h0;
    posClosed = 1'b0;
  end
  // Mechanism moves only after the coil has been energised long enough
  always @(posedge mclk) begin
    runCnt <= (closeDrive ^ openDrive) ? runCnt + 8'h1 : 8'h0;
    if (moveDelay != 4'h0 && (closeDrive ^ openDrive) && runCnt + 8'h1 >= {4'h0, moveDelay}) begin
      posClosed <= closeDrive;
    end
  end
  // Force 1 gives both low, force 2 both high
  assign closedAux = (forceLvl == 2'h1) ? 1'b0 : (forceLvl == 2'h2) ? 1'b1 : posClosed;
  assign openAux   = (forceLvl == 2'h1) ? 1'b0 : (forceLvl == 2'h2) ? 1'b1 : !posClosed;
endmodule

// ### verif/sps_supervisor_checker.sv
`timescale 1ns/1ps
module sps_supervisor_checker #(
  parameter int TW = 16
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // Register port
  input wire logic [4:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdata,
  // Contacts and relays
  input wire logic        closedAux,
  input wire logic        openAux,
  input wire logic        closeDrive,
  input wire logic        openDrive,
  // Position
  input wire logic        atClosed,
  input wire logic        atOpen,
  input wire logic        inTransit,
  input wire logic        posFault,
  input wire logic [1:0]  posCode,
  input wire logic        singleContactFlag,
  input wire logic        commandSucceeded,
  input wire logic        irq
);
  logic        cmdWr;
  logic        cfgOk;
  logic [31:0] trvC_ff, trvO_ff, runC_ff, runO_ff;
  logic [1:0]  cfg_ff;
  logic [2:0]  age_ff;
  assign cmdWr = regWr && (regAddr == sps_pkg::ADDR_COMMAND);
  assign cfgOk = (age_ff == 3'h7);
  // Shadow of timer counts and config, drive run lengths
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      trvC_ff <= 32'(sps_pkg::CLOSE_TRV_RESET);
      trvO_ff <= 32'(sps_pkg::OPEN_TRV_RESET);
      runC_ff <= 32'h0;
      runO_ff <= 32'h0;
      cfg_ff  <= sps_pkg::CFG_RESET;
      age_ff  <= 3'h0;
    end else begin
      if (regWr && regAddr == sps_pkg::ADDR_CLOSE_TRV) trvC_ff <= regWdata;
      if (regWr && regAddr == sps_pkg::ADDR_OPEN_TRV) trvO_ff <= regWdata;
      runC_ff <= (cmdWr || !closeDrive) ? 32'h0 : runC_ff + 32'h1;
      runO_ff <= (cmdWr || !openDrive) ? 32'h0 : runO_ff + 32'h1;
      if (regWr && regAddr == sps_pkg::ADDR_CONFIG) begin
        cfg_ff <= regWdata[1:0];
        age_ff <= 3'h0;
      end else if (!cfgOk) begin
        age_ff <= age_ff + 3'h1;
      end
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_one_flag: assert property ($onehot({atClosed, atOpen, inTransit, posFault}))
    else $error("position flags not one-hot");
  chk_pos_code: assert property (cfgOk && cfg_ff != 2'h0 |->
    (atOpen == (posCode == sps_pkg::CODE_OPEN)) && (atClosed == (posCode == sps_pkg::CODE_CLOSED)))
    else $error("position code disagrees with flags");
  chk_fault_code: assert property (posFault |-> posCode == sps_pkg::CODE_FAULT)
    else $error("fault flag without code 3");
  chk_close_start: assert property (cmdWr && regWdata[1:0] == 2'h1 |-> ##[1:2] closeDrive)
    else $error("close command without close drive");
  chk_open_prio: assert property (cmdWr && regWdata[1] |-> ##[1:2] (openDrive && !closeDrive))
    else $error("open command not driven with priority");
  chk_transit_start: assert property ($rose(closeDrive) && cfg_ff == 2'h3
    |-> ##[0:2] inTransit) else $error("no transit after close start");
  chk_close_len: assert property (runC_ff <= trvC_ff)
    else $error("close drive longer than travel time");
  chk_open_len: assert property (runO_ff <= trvO_ff)
    else $error("open drive longer than travel time");
  chk_single_flag: assert property (cfgOk |-> singleContactFlag == (cfg_ff == 2'h1 || cfg_ff == 2'h2))
    else $error("single contact flag wrong");
  cover property ($rose(posFault));
  cover property ($rose(commandSucceeded));
  cover property ($rose(irq));
  cover property (singleContactFlag && inTransit);
endmodule
bind sps_supervisor sps_supervisor_checker #(.TW(TW)) i_sps_supervisor_checker (
  .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .closedAux(closedAux), .openAux(openAux),
  .closeDrive(closeDrive), .openDrive(openDrive), .atClosed(atClosed), .atOpen(atOpen),
  .inTransit(inTransit), .posFault(posFault), .posCode(posCode),
  .singleContactFlag(singleContactFlag), .commandSucceeded(commandSucceeded), .irq(irq));

// ### verif/sps_supervisor_tb_top.sv
`timescale 1ns/1ps
module sps_supervisor_tb_top;
  localparam int CT = 20;
  localparam int OT = 12;
  typedef struct packed {
    logic [1:0] cfg;
    logic [1:0] cmd;
    logic [3:0] dly;
    logic [1:0] frc;
    logic [3:0] stl;
    logic [1:0] code;
    logic [1:0] succ;
    logic [7:0] drv;
    logic       trn;
  } sps_row_s;
  sps_row_s    rows [12];
  logic        mclk, rst_b, regWr, regRd, closedAux, openAux, closeDrive, openDrive, irq;
  logic        atClosed, atOpen, inTransit, posFault, singleContactFlag, commandSucceeded;
  logic [4:0]  regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [1:0]  posCode, forceLvl;
  logic [3:0]  moveDelay;
  logic [7:0]  drvCnt;
  int          failCount, comparisons, cycles;
  sps_supervisor i_sps_supervisor (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .closedAux(closedAux), .openAux(openAux), .closeDrive(closeDrive), .openDrive(openDrive),
    .atClosed(atClosed), .atOpen(atOpen), .inTransit(inTransit), .posFault(posFault),
    .posCode(posCode), .singleContactFlag(singleContactFlag),
    .commandSucceeded(commandSucceeded), .irq(irq));
  sps_contacts_model i_sps_contacts_model (.mclk(mclk), .closeDrive(closeDrive),
    .openDrive(openDrive), .moveDelay(moveDelay), .forceLvl(forceLvl),
    .closedAux(closedAux), .openAux(openAux));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failCount++;
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdReg(input logic [4:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  // Wait n cycles, counting cycles with a relay energised
  task automatic run(input int n);
    repeat (n) begin
      #1;
      drvCnt = drvCnt + {7'h0, closeDrive | openDrive};
      @(posedge mclk);
    end
  endtask
  task automatic results;
    if (failCount == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rst_b, regWr, regRd, regAddr, regWdata, forceLvl, moveDelay} = '0;
    {failCount, comparisons, cycles} = '0;
    // cfg cmd dly frc stl code succ drv trn
    rows[0]  = '{2'h3, 2'h1, 4'h2, 2'h0, 4'h0, 2'h2, 2'h1, 8'h00, 1'h1};
    rows[1]  = '{2'h3, 2'h3, 4'h2, 2'h0, 4'h0, 2'h1, 2'h1, 8'h00, 1'h1};
    rows[2]  = '{2'h3, 2'h1, 4'h0, 2'h0, 4'h0, 2'h3, 2'h0, 8'h14, 1'h1};
    rows[3]  = '{2'h3, 2'h2, 4'h2, 2'h0, 4'h0, 2'h1, 2'h1, 8'h00, 1'h0};
    rows[4]  = '{2'h3, 2'h1, 4'h0, 2'h2, 4'h0, 2'h3, 2'h0, 8'h14, 1'h1};
    rows[5]  = '{2'h1, 2'h1, 4'h2, 2'h0, 4'h0, 2'h2, 2'h1, 8'h00, 1'h1};
    rows[6]  = '{2'h1, 2'h2, 4'h2, 2'h0, 4'h0, 2'h1, 2'h0, 8'hff, 1'h0};
    rows[7]  = '{2'h2, 2'h1, 4'h2, 2'h0, 4'h0, 2'h2, 2'h0, 8'hff, 1'h0};
    rows[8]  = '{2'h2, 2'h2, 4'h2, 2'h0, 4'h0, 2'h1, 2'h1, 8'h00, 1'h1};
    rows[9]  = '{2'h1, 2'h1, 4'h0, 2'h0, 4'h5, 2'h2, 2'h0, 8'h14, 1'h1};
    rows[10] = '{2'h2, 2'h2, 4'h0, 2'h1, 4'h5, 2'h1, 2'h0, 8'h0c, 1'h1};
    rows[11] = '{2'h0, 2'h1, 4'h2, 2'h0, 4'h0, 2'h3, 2'h2, 8'hff, 1'h0};
    repeat (8) @(posedge mclk);
    #1;
    chk(inTransit, 1'b1);
    chk(closeDrive, 1'b0);
    @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rdReg(sps_pkg::ADDR_CONFIG);
    chk(rd, 32'(sps_pkg::CFG_RESET));
    rdReg(sps_pkg::ADDR_CLOSE_TRV);
    chk(rd, 32'(sps_pkg::CLOSE_TRV_RESET));
    rdReg(5'h1e);
    chk(rd, 32'h0);
    wr(sps_pkg::ADDR_CLOSE_TRV, 32'(CT));
    wr(sps_pkg::ADDR_OPEN_TRV, 32'(OT));
    rdReg(sps_pkg::ADDR_OPEN_TRV);
    chk(rd, 32'(OT));
    foreach (rows[i]) begin
      @(posedge mclk);
      moveDelay <= rows[i].dly;
      forceLvl <= rows[i].frc;
      wr(sps_pkg::ADDR_SETTLE, {28'h0, rows[i].stl});
      wr(sps_pkg::ADDR_CONFIG, {30'h0, rows[i].cfg});
      wr(sps_pkg::ADDR_COMMAND, {30'h0, rows[i].cmd});
      drvCnt = 8'h0;
      run(3);
      #1;
      if (rows[i].trn) chk(inTransit, 1'b1);
      if (rows[i].trn) chk(posCode, sps_pkg::CODE_TRANSIT);
      run(42);
      #1;
      chk(posCode, rows[i].code);
      chk({atClosed, atOpen, posFault},
          {rows[i].code == 2'h2, rows[i].code == 2'h1, rows[i].code == 2'h3});
      if (rows[i].succ != 2'h2) chk(commandSucceeded, rows[i].succ[0]);
      if (rows[i].drv == 8'h0) chk(drvCnt > 0 && drvCnt < (rows[i].cmd[1] ? OT : CT), 1'b1);
      else if (rows[i].drv != 8'hff) chk(drvCnt, rows[i].drv);
      chk(irq, 1'b0);
      rdReg(sps_pkg::ADDR_STATUS);
      chk(rd[1:0], rows[i].code);
      chk(rd[6], rows[i].cfg == 2'h1 || rows[i].cfg == 2'h2);
    end
    wr(sps_pkg::ADDR_IRQ_STAT, 32'h3);
    wr(sps_pkg::ADDR_IRQ_MASK, 32'h2);
    @(posedge mclk);
    moveDelay <= 4'h0;
    wr(sps_pkg::ADDR_CONFIG, 32'h3);
    wr(sps_pkg::ADDR_COMMAND, 32'h2);
    run(45);
    #1;
    chk(irq, 1'b1);
    rdReg(sps_pkg::ADDR_IRQ_STAT);
    chk(rd[1], 1'b1);
    wr(sps_pkg::ADDR_IRQ_STAT, 32'h2);
    run(3);
    #1;
    chk(irq, 1'b0);
    wr(sps_pkg::ADDR_COMMAND, 32'h2);
    run(5);
    rst_b <= 1'b0;
    @(posedge mclk);
    #1;
    chk(openDrive, 1'b0);
    chk(inTransit, 1'b1);
    @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    rdReg(sps_pkg::ADDR_CONFIG);
    chk(rd, 32'(sps_pkg::CFG_RESET));
    rdReg(sps_pkg::ADDR_CLOSE_TRV);
    chk(rd, 32'(sps_pkg::CLOSE_TRV_RESET));
    results();
  end
endmodule
